// ### verilog/ucg_top.sv
`timescale 1ns/1ps
// ****************************************
// user feature and calibration registers
// ****************************************
module ucg_top (
    input  wire logic        mclk,          // system clock
    input  wire logic        arst_n,        // async reset, active low
    input  wire logic        clk_en,        // freezes state when low
    input  wire logic [7:0]  cmd_code,      // pmbus command code
    input  wire logic [15:0] cmd_wdata,     // write word
    input  wire logic        cmd_write,     // write strobe
    input  wire logic        write_protect, // blocks writes when high
    input  wire logic        lo_cmd,        // low-side gate command
    input  wire logic        hi_cmd,        // high-side gate command
    input  wire logic        stage_en,      // driver stage enable
    input  wire logic        stage_pwm,     // driver stage modulation
    input  wire logic        pgood_level,   // power-good state
    output logic [15:0]      cmd_rdata,     // read word for cmd_code
    output logic [9:0]       min_duty_num,  // limit numerator over 512
    output logic             min_duty_en,   // limit active
    output logic             margin_ratio_mode,    // use margin_ratio_setting
    output logic             external_temp_sensor, // sensor enabled
    output logic             ext_temp_fault_sel,   // faults from sensor
    output logic [4:0]       cal_exponent,  // signed exponent
    output logic [10:0]      cal_mantissa,  // signed mantissa
    output logic             low_side_drive_out,  // low pin
    output logic             high_side_drive_out, // high pin
    output logic             power_good_out,      // pg pin value
    output logic             power_good_oe        // pg pin enable
);
    import ucg_pkg::*;

    // ****************************************
    // local constants
    // ****************************************
    // the +1 of the field, doubled, so the numerator is never zero
    localparam logic [9:0] UCG_MIN_OFS = 10'h002;
    // numerator that the default word decodes to
    localparam logic [9:0] UCG_MIN_NUM_RST =
        {4'h0, UCG_CFG_RESET[UCG_MIN_HI:UCG_MIN_LO], 1'b0} + UCG_MIN_OFS;

    // ****************************************
    // stored words and next values
    // ****************************************
    logic [15:0] cfg_q;     // feature word, unused bits held at zero
    logic [15:0] cfg_d;     // next feature word
    logic [15:0] cal_q;     // calibration word, linear format
    logic [15:0] cal_d;     // next calibration word
    logic [15:0] rd_d;      // next read word
    logic        wr_ok;     // write strobe not blocked by protection
    // next values of the decoded outputs
    logic [4:0]  min_field; // raw limit field of the next word
    logic [9:0]  min_num_d; // next limit numerator
    logic        min_en_d;  // next limit enable
    logic        mrg_d;     // next margin ratio select
    logic        xen_d;     // next sensor enable
    logic        xsel_d;    // next fault source select
    logic [4:0]  exp_d;     // next signed exponent
    logic [10:0] man_d;     // next signed mantissa

    // ****************************************
    // register write path and read mux
    // ****************************************
    // a protected write is dropped with no indication; the host has
    // to read the word back to learn whether it landed
    always_comb begin
        wr_ok = cmd_write && !write_protect;
        cfg_d = cfg_q;
        cal_d = cal_q;
        rd_d  = 16'h0000; // unknown codes read zero
        if (wr_ok && cmd_code == UCG_CMD_USER_CFG) begin
            // unused bits never reach the register
            cfg_d = cmd_wdata & UCG_CFG_MASK;
        end
        if (wr_ok && cmd_code == UCG_CMD_IIN_CAL) begin
            cal_d = cmd_wdata;
        end
        // the read word is taken from the stored value, so a write shows
        // on the read port one edge after it lands
        if (cmd_code == UCG_CMD_USER_CFG) begin
            rd_d = cfg_q;
        end else if (cmd_code == UCG_CMD_IIN_CAL) begin
            rd_d = cal_q;
        end
    end

    // ****************************************
    // field decode of the next words
    // ****************************************
    // decoding the next word rather than the stored one lets every
    // decoded output change at the same edge as its register
    always_comb begin
        min_field = cfg_d[UCG_MIN_HI:UCG_MIN_LO];
        // 2x(value+1) numerator; the 512 denominator is fixed downstream
        min_num_d = {4'h0, min_field, 1'b0} + UCG_MIN_OFS;
        // the limit is only a candidate until its enable bit is set
        min_en_d  = cfg_d[UCG_MDEN_BIT];
        mrg_d     = cfg_d[UCG_MRG_BIT];
        xen_d     = cfg_d[UCG_XEN_BIT];
        // the fault source is the raw bit, not gated by the sensor
        // enable; fault logic downstream has to look at both
        xsel_d    = cfg_d[UCG_XSEL_BIT];
        // sign handling is left to the current arithmetic downstream
        exp_d     = cal_d[UCG_EXP_HI:UCG_EXP_LO];
        man_d     = cal_d[UCG_MAN_HI:0];
    end

    // ****************************************
    // stored words and read word
    // ****************************************
    // a low clock enable freezes the words and the read word alike
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q     <= UCG_CFG_RESET;
            cal_q     <= UCG_CAL_RESET;
            cmd_rdata <= 16'h0000;
        end else if (clk_en) begin
            cfg_q     <= cfg_d;
            cal_q     <= cal_d;
            cmd_rdata <= rd_d;
        end
    end

    // ****************************************
    // registered decodes
    // ****************************************
    // reset values come from the default words, so the decoded outputs
    // agree with the registers straight out of reset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            min_duty_num         <= UCG_MIN_NUM_RST;
            min_duty_en          <= UCG_CFG_RESET[UCG_MDEN_BIT];
            margin_ratio_mode    <= UCG_CFG_RESET[UCG_MRG_BIT];
            external_temp_sensor <= UCG_CFG_RESET[UCG_XEN_BIT];
            ext_temp_fault_sel   <= UCG_CFG_RESET[UCG_XSEL_BIT];
            cal_exponent         <= UCG_CAL_RESET[UCG_EXP_HI:UCG_EXP_LO];
            cal_mantissa         <= UCG_CAL_RESET[UCG_MAN_HI:0];
        end else if (clk_en) begin
            min_duty_num         <= min_num_d;
            min_duty_en          <= min_en_d;
            margin_ratio_mode    <= mrg_d;
            external_temp_sensor <= xen_d;
            ext_temp_fault_sel   <= xsel_d;
            cal_exponent         <= exp_d;
            cal_mantissa         <= man_d;
        end
    end

    // ****************************************
    // pin mapping
    // ****************************************
    ucg_drive_map u_map (
        .mclk                (mclk),
        .arst_n              (arst_n),
        .clk_en              (clk_en),
        .stage_mode          (cfg_q[UCG_DRV_BIT]),
        .pgood_push_pull     (cfg_q[UCG_PGPP_BIT]),
        .lo_cmd              (lo_cmd),
        .hi_cmd              (hi_cmd),
        .stage_en            (stage_en),
        .stage_pwm           (stage_pwm),
        .pgood_level         (pgood_level),
        .low_side_drive_out  (low_side_drive_out),
        .high_side_drive_out (high_side_drive_out),
        .power_good_out      (power_good_out),
        .power_good_oe       (power_good_oe)
    );

    // ****************************************
    // register checks
    // ****************************************
    // unused bits must never be stored, whatever a host writes
    unused_zero_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (cfg_q & ~UCG_CFG_MASK) == 16'h0000)
        else $error("unused feature bit set");
    // an allowed write lands at the edge that takes it
    cfg_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (clk_en && cmd_write && !write_protect && cmd_code == UCG_CMD_USER_CFG)
        |=> cfg_q == ($past(cmd_wdata) & UCG_CFG_MASK))
        else $error("feature write lost");
    // the calibration word is stored whole, no field is dropped
    cal_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (clk_en && cmd_write && !write_protect && cmd_code == UCG_CMD_IIN_CAL)
        |=> cal_q == $past(cmd_wdata))
        else $error("calibration write lost");
    // protection must hold both words at the edge it is sampled
    protect_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (write_protect) |=> $stable(cal_q) && $stable(cfg_q))
        else $error("protected write took effect");
    // a read shows the word that was stored before the edge
    cfg_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (clk_en && cmd_code == UCG_CMD_USER_CFG) |=> cmd_rdata == $past(cfg_q))
        else $error("feature read word wrong");
    cal_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (clk_en && cmd_code == UCG_CMD_IIN_CAL) |=> cmd_rdata == $past(cal_q))
        else $error("calibration read word wrong");
    // the first edge after release still sees the default words
    reset_word_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(arst_n) |-> cfg_q == UCG_CFG_RESET && cal_q == UCG_CAL_RESET)
        else $error("default words wrong after reset");
    // a low clock enable must hold every stored word
    freeze_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !clk_en |=> $stable(cfg_q) && $stable(cal_q) && $stable(cmd_rdata))
        else $error("state moved while frozen");

    // ****************************************
    // decode checks
    // ****************************************
    min_duty_a: assert property (@(posedge mclk) disable iff (!arst_n)
        min_duty_num == {4'h0, cfg_q[UCG_MIN_HI:UCG_MIN_LO], 1'b0} + UCG_MIN_OFS)
        else $error("min duty numerator wrong");
    min_en_a: assert property (@(posedge mclk) disable iff (!arst_n)
        min_duty_en == cfg_q[UCG_MDEN_BIT])
        else $error("min duty enable wrong");
    margin_sel_a: assert property (@(posedge mclk) disable iff (!arst_n)
        margin_ratio_mode == cfg_q[UCG_MRG_BIT])
        else $error("margin ratio select wrong");
    ext_sel_a: assert property (@(posedge mclk) disable iff (!arst_n)
        external_temp_sensor == cfg_q[UCG_XEN_BIT]
        && ext_temp_fault_sel == cfg_q[UCG_XSEL_BIT])
        else $error("sensor select wrong");
    // both linear fields together must rebuild the stored word
    cal_split_a: assert property (@(posedge mclk) disable iff (!arst_n)
        {cal_exponent, cal_mantissa} == cal_q)
        else $error("linear fields wrong");
endmodule

// ### verilog/ucg_pkg.sv
package ucg_pkg;
    // ****************************************
    // command codes and reset values
    // ****************************************
    localparam logic [7:0]  UCG_CMD_USER_CFG = 8'hD1; // feature word command
    localparam logic [7:0]  UCG_CMD_IIN_CAL  = 8'hD2; // calibration word command
    localparam logic [15:0] UCG_CFG_RESET    = 16'h0402; // feature word default
    localparam logic [15:0] UCG_CAL_RESET    = 16'hC200; // calibration default
    localparam logic [15:0] UCG_CFG_MASK     = 16'hFC97; // implemented feature bits
    // ****************************************
    // field positions
    // ****************************************
    localparam int UCG_MIN_HI   = 15; // min duty field msb
    localparam int UCG_MIN_LO   = 11; // min duty field lsb
    localparam int UCG_DRV_BIT  = 10; // integrated driver select
    localparam int UCG_MDEN_BIT = 7;  // min duty enable
    localparam int UCG_MRG_BIT  = 4;  // margin ratio enable
    localparam int UCG_PGPP_BIT = 2;  // power-good push-pull
    localparam int UCG_XEN_BIT  = 1;  // external sensor enable
    localparam int UCG_XSEL_BIT = 0;  // external sensor fault select
    localparam int UCG_EXP_HI   = 15; // exponent msb
    localparam int UCG_EXP_LO   = 11; // exponent lsb
    localparam int UCG_MAN_HI   = 10; // mantissa msb
endpackage

// ### verilog/ucg_drive_map.sv
`timescale 1ns/1ps
// ****************************************
// drive pin mapping and power-good style
// ****************************************
module ucg_drive_map (
    input  wire logic mclk,                // system clock
    input  wire logic arst_n,              // async reset, active low
    input  wire logic clk_en,              // freezes state when low
    input  wire logic stage_mode,          // integrated driver stage mode
    input  wire logic pgood_push_pull,     // power-good style
    input  wire logic lo_cmd,              // low-side gate command
    input  wire logic hi_cmd,              // high-side gate command
    input  wire logic stage_en,            // driver stage enable
    input  wire logic stage_pwm,           // driver stage modulation
    input  wire logic pgood_level,         // power-good state
    output logic      low_side_drive_out,  // low pin
    output logic      high_side_drive_out, // high pin
    output logic      power_good_out,      // power-good pin value
    output logic      power_good_oe        // power-good pin enable
);
    logic lo_d;    // next low pin
    logic hi_d;    // next high pin
    logic pgood_d; // next power-good value
    logic oe_d;    // next power-good enable

    // ****************************************
    // combinational pin selection
    // ****************************************
    always_comb begin
        if (stage_mode) begin
            lo_d = stage_en;
            hi_d = stage_pwm;
        end else begin
            lo_d = lo_cmd;
            hi_d = hi_cmd;
        end
        // open drain only ever drives a low
        pgood_d = pgood_push_pull ? pgood_level : 1'b0;
        oe_d    = pgood_push_pull ? 1'b1 : !pgood_level;
    end

    // pins come from flops; reset keeps gates off and power-good low
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            low_side_drive_out  <= 1'b0;
            high_side_drive_out <= 1'b0;
            power_good_out      <= 1'b0;
            power_good_oe       <= 1'b1;
        end else if (clk_en) begin
            low_side_drive_out  <= lo_d;
            high_side_drive_out <= hi_d;
            power_good_out      <= pgood_d;
            power_good_oe       <= oe_d;
        end
    end

    pgood_od_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (clk_en && !pgood_push_pull) |=> (power_good_out == 1'b0))
        else $error("open drain power-good drove high");
    pgood_pp_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (clk_en && pgood_push_pull) |=> power_good_oe && power_good_out == $past(pgood_level))
        else $error("push-pull power-good not driven");
    drv_map_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (clk_en && stage_mode) |=> low_side_drive_out == $past(stage_en)
        && high_side_drive_out == $past(stage_pwm))
        else $error("pins not stage enable and modulation");
    drv_direct_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (clk_en && !stage_mode) |=> low_side_drive_out == $past(lo_cmd)
        && high_side_drive_out == $past(hi_cmd))
        else $error("pins not direct gate commands");
endmodule

// ### sim/ucg_host.sv
`timescale 1ns/1ps
// ****************************************
// host stand-in issuing whole-word commands
// ****************************************
module ucg_host (
    input  wire logic  mclk,      // system clock
    output logic [7:0]  cmd_code,  // command code
    output logic [15:0] cmd_wdata, // write word
    output logic        cmd_write  // write strobe
);
    // idle bus at time zero
    initial begin
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
        cmd_write = 1'b0;
    end
    // one word per write; gap gives a slow host
    task automatic wr(input logic [7:0] c, input logic [15:0] d, input int gap);
        @(negedge mclk);
        cmd_code  = c;
        cmd_wdata = d;
        cmd_write = 1'b1;
        @(negedge mclk);
        cmd_write = 1'b0;
        // released data must not look like a held word
        cmd_wdata = ~d;
        repeat (gap) @(negedge mclk);
    endtask
    // select a code; its word is settled one edge later
    task automatic sel(input logic [7:0] c);
        @(negedge mclk);
        cmd_code = c;
        @(negedge mclk);
    endtask
endmodule

// ### sim/ucg_top_tb_top.sv
`timescale 1ns/1ps
// ****************************************
// bench: random command traffic vs model
// ****************************************
module ucg_top_tb_top;
    import ucg_pkg::*;
    logic        mclk   = 1'b0; // 40 mhz clock
    logic        arst_n = 1'b0; // reset, active low
    logic        clk_en = 1'b1; // state advance
    logic        wp     = 1'b0; // write protect
    logic [4:0]  pins   = 5'h00; // lo, hi, stage en, pwm, power-good
    logic [7:0]  code;          // host code
    logic [15:0] wdata;         // host data
    logic        wstb;          // host strobe
    logic [15:0] rdata;         // read word
    logic [9:0]  mdn;           // min duty numerator
    logic [4:0]  cexp;          // cal exponent
    logic [10:0] cman;          // cal mantissa
    logic        mde, mrm, xen, xsel, lo_o, hi_o, pgood_o, pgood_oe; // decoded outs
    logic [15:0] cfg_m, cal_m;  // model words
    logic [31:0] seed = 32'h0000_0007; // xorshift state
    logic [31:0] r;             // random draw
    int          mismatches = 0;
    int          total_checks = 0;
    // ****************************************
    // clock, host and design
    // ****************************************
    always #12.5 mclk = ~mclk;
    ucg_host i_host (.mclk(mclk), .cmd_code(code), .cmd_wdata(wdata), .cmd_write(wstb));
    ucg_top i_dut (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .cmd_code(code),
        .cmd_wdata(wdata), .cmd_write(wstb), .write_protect(wp), .lo_cmd(pins[4]),
        .hi_cmd(pins[3]), .stage_en(pins[2]), .stage_pwm(pins[1]), .pgood_level(pins[0]),
        .cmd_rdata(rdata), .min_duty_num(mdn), .min_duty_en(mde),
        .margin_ratio_mode(mrm), .external_temp_sensor(xen), .ext_temp_fault_sel(xsel),
        .cal_exponent(cexp), .cal_mantissa(cman), .low_side_drive_out(lo_o),
        .high_side_drive_out(hi_o), .power_good_out(pgood_o), .power_good_oe(pgood_oe));
    // xorshift source, fixed start
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // ****************************************
    // compare, model and closing tasks
    // ****************************************
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // reset for 16 cycles, model back to defaults
    task rst;
        arst_n = 1'b0;
        repeat (16) @(negedge mclk);
        arst_n = 1'b1;
        cfg_m  = UCG_CFG_RESET;
        cal_m  = UCG_CAL_RESET;
    endtask
    // model takes a write only when enabled and unprotected
    task dw(input logic [7:0] c, input logic [15:0] d, input int gap);
        if (clk_en && !wp && c == UCG_CMD_USER_CFG) cfg_m = d & UCG_CFG_MASK;
        if (clk_en && !wp && c == UCG_CMD_IIN_CAL) cal_m = d;
        i_host.wr(c, d, gap);
        clk_en = 1'b1;
        wp     = 1'b0;
    endtask
    // read a code back and compare every result
    task rd(input logic [7:0] c);
        i_host.sel(c);
        chk(rdata, c == UCG_CMD_USER_CFG ? cfg_m : c == UCG_CMD_IIN_CAL ? cal_m : 16'h0000);
        chk({6'h00, mdn}, 16'(2 * (cfg_m[15:11] + 1)));
        chk({15'h0000, mde}, {15'h0000, cfg_m[7]});
        chk({15'h0000, mrm}, {15'h0000, cfg_m[4]});
        chk({14'h0000, xen, xsel}, {14'h0000, cfg_m[1:0]});
        chk({cexp, cman}, cal_m);
        chk({14'h0000, lo_o, hi_o}, {14'h0000, cfg_m[10] ? pins[2:1] : pins[4:3]});
        chk({14'h0000, pgood_o, pgood_oe},
            {14'h0000, cfg_m[2] ? {pins[0], 1'b1} : {1'b0, ~pins[0]}});
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst();
        rd(UCG_CMD_USER_CFG);
        rd(UCG_CMD_IIN_CAL);
        rd(8'hD3);
        dw(UCG_CMD_USER_CFG, 16'hFFFF, 0);
        rd(UCG_CMD_USER_CFG);
        // random codes, protect, freeze, slow host and pin levels
        for (int i = 0; i < 120; i++) begin
            r      = xs();
            wp     = r[0] & r[1];
            clk_en = ~(r[2] & r[3] & r[4]);
            dw(r[6:5] == 2'b00 ? UCG_CMD_IIN_CAL : r[6:5] == 2'b01 ? r[31:24] :
               UCG_CMD_USER_CFG, 16'(xs() >> 16), r[8] ? 2 : 0);
            pins = 5'(xs() >> 27);
            rd(r[9] ? UCG_CMD_USER_CFG : UCG_CMD_IIN_CAL);
        end
        // second reset in mid-run restores defaults
        rst();
        rd(UCG_CMD_USER_CFG);
        rd(UCG_CMD_IIN_CAL);
        test_done();
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge mclk);
        mismatches++;
        test_done();
    end
endmodule
